// ---- hw/pcm_pkg.sv ----
// constants for the port c alternate-function mux
package pcm_pkg;
	localparam int PCM_PORT_W = 8;
	localparam int PCM_ADC_W = 6;
	localparam int PCM_RESET_BIT = 6;
	localparam int PCM_SCL_BIT = 5;
	localparam int PCM_SDA_BIT = 4;
	localparam int PCM_PCSRC_C_BASE = 8;
	localparam int PCM_PCSRC_D_BASE = 16;
	localparam int PCM_PD_EXT0_BIT = 2;
	localparam int PCM_PD_EXT1_BIT = 3;
	localparam int PCM_PD_T0_BIT = 4;
	localparam int PCM_PD_T1_BIT = 5;
	localparam int PCM_PD_CMP_POS_BIT = 6;
	localparam int PCM_PD_CMP_NEG_BIT = 7;
	localparam int PCM_CLK_PERIOD_NS = 10;
	localparam int PCM_SPIKE_NS = 50;
	// a pulse shorter than the spike time must not pass: round up
	localparam int PCM_SPIKE_CYC =
		(PCM_SPIKE_NS + PCM_CLK_PERIOD_NS - 1) / PCM_CLK_PERIOD_NS;
	localparam logic [2:0] PCM_SPIKE_CNT_RST = 3'h0;
	localparam logic [7:0] PCM_BYTE_RST = 8'h00;
endpackage : pcm_pkg

// ---- hw/pcm_port_c_mux.sv ----
// port c alternate-function override logic with port d routing
`timescale 1ns/1ps

// How it works
// R1 - with the reset-disable fuse programmed, bit 6 is a plain input and reset comes only from power-on and brown-out.
// R2 - with the fuse unprogrammed, bit 6 feeds the reset circuit and is not usable as an input.
// R3 - while bit 6 is the reset pin its direction, output and input bits read zero.
// R4 - with two-wire enabled, bit 5 leaves port control and becomes the clock line.
// R5 - with two-wire enabled, bit 4 leaves port control and becomes the data line.
// R6 - each two-wire line input passes a filter rejecting pulses under 50 ns.
// R7 - two-wire lines are open drain: they only pull low.
// R8 - port c bit n feeds pin-change source 8 plus n.
// R9 - port c bits 0 to 5 feed analog channels 0 to 5.
// R10 - port d bits 0 to 7 feed pin-change sources 16 to 23.
// R11 - port d bits 2 and 3 carry external interrupt inputs 0 and 1.
// R12 - port d bits 4 and 5 carry the timer 0 and timer 1 count inputs.
// R13 - port d bits 6 and 7 carry the comparator positive and negative inputs.
// R14 - an analog pin's digital buffer is off when its disable bit is set unless its pin-change source is enabled.
// R15 - in two-wire mode pull-up follows the output bit gated by the global disable, direction follows the line drive, value forced low.
// R16 - the global pull-up disable turns off every port pull-up; the code keeps the bit 6 pull-up on while bit 6 is the reset pin.
module pcm_port_c_mux
	import pcm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_reset_pin_disable_fuse,
	input wire logic i_two_wire_enable,
	input wire logic i_global_pullup_disable,
	input wire logic i_pin_change_group1_enable,
	input wire logic [7:0] i_pin_change_mask_c,
	input wire logic [5:0] i_analog_digital_input_disable,
	input wire logic [7:0] i_portc_direction,
	input wire logic [7:0] i_portc_output,
	input wire logic i_scl_out,
	input wire logic i_sda_out,
	input wire logic [7:0] i_portc_pin,
	input wire logic [7:0] i_portd_pin,
	output logic [7:0] o_portc_pin_out,
	output logic [7:0] o_portc_pin_oe,
	output logic [7:0] o_portc_pullup,
	output logic [7:0] o_portc_direction_rd,
	output logic [7:0] o_portc_output_rd,
	output logic [7:0] o_portc_input_rd,
	output logic o_ext_reset_req,
	output logic [15:8] o_pin_change_src_c,
	output logic [23:16] o_pin_change_src_d,
	output logic [5:0] o_analog_ch_en,
	output logic o_scl_in,
	output logic o_sda_in,
	output logic o_external_irq_input_0,
	output logic o_external_irq_input_1,
	output logic o_timer0_count_input,
	output logic o_timer1_count_input,
	output logic o_comparator_pos_sel,
	output logic o_comparator_neg_sel
);
	logic [7:0] pc_meta_reg;
	logic [7:0] pc_sync_reg;
	logic [7:0] pd_meta_reg;
	logic [7:0] pd_sync_reg;
	logic [7:0] dig_in_en;
	logic [7:0] drv_oe;
	logic [7:0] pull_en;
	logic reset_mode;
	logic [2:0] scl_cnt_reg;
	logic [2:0] sda_cnt_reg;
	logic scl_filt_reg;
	logic sda_filt_reg;

	// spike filter step: a new level must hold for the full spike time
	function automatic logic [2:0] pcm_filt_cnt(input logic sync,
		input logic filt, input logic [2:0] cnt);
		if (sync == filt)
			return PCM_SPIKE_CNT_RST;
		else if (cnt == 3'(PCM_SPIKE_CYC - 1))
			return PCM_SPIKE_CNT_RST;
		else
			return cnt + 3'h1;
	endfunction : pcm_filt_cnt

	// two-flop synchronisers for both ports
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pc_meta_reg <= PCM_BYTE_RST;
			pc_sync_reg <= PCM_BYTE_RST;
			pd_meta_reg <= PCM_BYTE_RST;
			pd_sync_reg <= PCM_BYTE_RST;
		end
		else
		begin
			pc_meta_reg <= i_portc_pin;
			pc_sync_reg <= pc_meta_reg;
			pd_meta_reg <= i_portd_pin;
			pd_sync_reg <= pd_meta_reg;
		end
	end

	// bit 6 is reset pin unless fuse programmed
	assign reset_mode = !i_reset_pin_disable_fuse; // [R1] [R2]

	// per-pin override combination
	always_comb
	begin
		for (int n = 0; n < PCM_PORT_W; n++)
		begin
			// normal port: pull-up on for dir 0 out 1 unless disabled
			pull_en[n] = !i_portc_direction[n] && i_portc_output[n]
				&& !i_global_pullup_disable; // [R16]
			drv_oe[n] = i_portc_direction[n];
			dig_in_en[n] = 1'b1;
		end
		for (int n = 0; n < PCM_ADC_W; n++)
			if (i_analog_digital_input_disable[n])
				dig_in_en[n] = i_pin_change_mask_c[n]
					&& i_pin_change_group1_enable; // [R14]
		if (reset_mode)
		begin
			pull_en[PCM_RESET_BIT] = 1'b1; // [R2]
			drv_oe[PCM_RESET_BIT] = 1'b0;
			dig_in_en[PCM_RESET_BIT] = 1'b0; // [R2]
		end
		if (i_two_wire_enable)
		begin
			pull_en[PCM_SCL_BIT] = i_portc_output[PCM_SCL_BIT]
				&& !i_global_pullup_disable; // [R15] [R16]
			pull_en[PCM_SDA_BIT] = i_portc_output[PCM_SDA_BIT]
				&& !i_global_pullup_disable; // [R15] [R16]
			drv_oe[PCM_SCL_BIT] = i_scl_out; // [R4] [R15]
			drv_oe[PCM_SDA_BIT] = i_sda_out; // [R5] [R15]
		end
	end

	// pin drive, pull-ups and readback
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_portc_pin_out <= PCM_BYTE_RST;
			o_portc_pin_oe <= PCM_BYTE_RST;
			o_portc_pullup <= PCM_BYTE_RST;
			o_portc_direction_rd <= PCM_BYTE_RST;
			o_portc_output_rd <= PCM_BYTE_RST;
			o_portc_input_rd <= PCM_BYTE_RST;
			o_ext_reset_req <= 1'b0;
		end
		else
		begin
			o_portc_pin_out <= i_portc_output;
			if (i_two_wire_enable)
			begin
				o_portc_pin_out[PCM_SCL_BIT] <= 1'b0; // [R7]
				o_portc_pin_out[PCM_SDA_BIT] <= 1'b0; // [R7]
			end
			o_portc_pin_oe <= drv_oe;
			o_portc_pullup <= pull_en;
			o_portc_direction_rd <= i_portc_direction;
			o_portc_output_rd <= i_portc_output;
			o_portc_input_rd <= pc_sync_reg & dig_in_en;
			if (reset_mode)
			begin
				o_portc_direction_rd[PCM_RESET_BIT] <= 1'b0; // [R3]
				o_portc_output_rd[PCM_RESET_BIT] <= 1'b0; // [R3]
				o_portc_input_rd[PCM_RESET_BIT] <= 1'b0; // [R3]
			end
			// low on bit 6 requests reset only in reset mode
			o_ext_reset_req <= reset_mode
				&& !pc_sync_reg[PCM_RESET_BIT]; // [R1] [R2]
		end
	end

	// pin-change, analog and port d routing
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_pin_change_src_c <= PCM_BYTE_RST;
			o_pin_change_src_d <= PCM_BYTE_RST;
			o_analog_ch_en <= 6'h00;
			o_external_irq_input_0 <= 1'b0;
			o_external_irq_input_1 <= 1'b0;
			o_timer0_count_input <= 1'b0;
			o_timer1_count_input <= 1'b0;
			o_comparator_pos_sel <= 1'b0;
			o_comparator_neg_sel <= 1'b0;
		end
		else
		begin
			o_pin_change_src_c <= pc_sync_reg & dig_in_en; // [R8]
			o_pin_change_src_d <= pd_sync_reg; // [R10]
			o_analog_ch_en <= i_analog_digital_input_disable; // [R9]
			o_external_irq_input_0 <= pd_sync_reg[PCM_PD_EXT0_BIT]; // [R11]
			o_external_irq_input_1 <= pd_sync_reg[PCM_PD_EXT1_BIT]; // [R11]
			o_timer0_count_input <= pd_sync_reg[PCM_PD_T0_BIT]; // [R12]
			o_timer1_count_input <= pd_sync_reg[PCM_PD_T1_BIT]; // [R12]
			o_comparator_pos_sel <= pd_sync_reg[PCM_PD_CMP_POS_BIT]; // [R13]
			o_comparator_neg_sel <= pd_sync_reg[PCM_PD_CMP_NEG_BIT]; // [R13]
		end
	end

	// spike filters on the two-wire lines
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			scl_cnt_reg <= PCM_SPIKE_CNT_RST;
			sda_cnt_reg <= PCM_SPIKE_CNT_RST;
			scl_filt_reg <= 1'b1;
			sda_filt_reg <= 1'b1;
		end
		else
		begin
			scl_cnt_reg <= pcm_filt_cnt(pc_sync_reg[PCM_SCL_BIT],
				scl_filt_reg, scl_cnt_reg); // [R6]
			sda_cnt_reg <= pcm_filt_cnt(pc_sync_reg[PCM_SDA_BIT],
				sda_filt_reg, sda_cnt_reg); // [R6]
			if (pc_sync_reg[PCM_SCL_BIT] != scl_filt_reg
				&& scl_cnt_reg == 3'(PCM_SPIKE_CYC - 1))
				scl_filt_reg <= pc_sync_reg[PCM_SCL_BIT]; // [R6]
			if (pc_sync_reg[PCM_SDA_BIT] != sda_filt_reg
				&& sda_cnt_reg == 3'(PCM_SPIKE_CYC - 1))
				sda_filt_reg <= pc_sync_reg[PCM_SDA_BIT]; // [R6]
		end
	end

	// filtered lines reach the interface only in two-wire mode
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_scl_in <= 1'b1;
			o_sda_in <= 1'b1;
		end
		else
		begin
			o_scl_in <= i_two_wire_enable ? scl_filt_reg : 1'b1; // [R4] [R6]
			o_sda_in <= i_two_wire_enable ? sda_filt_reg : 1'b1; // [R5] [R6]
		end
	end
endmodule : pcm_port_c_mux

// ---- tb/pcm_mux_sva.sv ----
// assertions for the port c alternate-function mux
`timescale 1ns/1ps
module pcm_mux_sva (
	input wire logic i_sys_clk, i_reset_n, i_reset_pin_disable_fuse,
	input wire logic i_two_wire_enable, i_global_pullup_disable, i_scl_out,
	input wire logic [7:0] i_pin_change_mask_c, i_portd_pin,
	input wire logic [5:0] i_analog_digital_input_disable, o_analog_ch_en,
	input wire logic [7:0] o_portc_pin_out, o_portc_pin_oe, o_portc_pullup,
	input wire logic [7:0] o_portc_output_rd, o_portc_input_rd,
	input wire logic [7:0] o_portc_direction_rd,
	input wire logic [23:16] o_pin_change_src_d
);
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);
	// overrides and routing tied to their causes, with exact latencies
	rst_pin_zero_a: assert property (!i_reset_pin_disable_fuse |=>
		{o_portc_direction_rd[6], o_portc_output_rd[6],
		o_portc_input_rd[6]} == 3'b000)
		else $error("reset pin bit reads nonzero");
	scl_drive_a: assert property (i_two_wire_enable |=>
		o_portc_pin_oe[5] == $past(i_scl_out)) else $error("clock line drive");
	line_low_a: assert property (i_two_wire_enable |=>
		o_portc_pin_out[5:4] == 2'b00) else $error("line driven high");
	tw_pullup_a: assert property (
		i_two_wire_enable && i_global_pullup_disable |=>
		o_portc_pullup[5:4] == 2'b00) else $error("line pull-up on");
	pull_off_a: assert property (
		i_global_pullup_disable && i_reset_pin_disable_fuse |=>
		o_portc_pullup == 8'h00) else $error("pull-up on while disabled");
	src_d_a: assert property ($past(i_reset_n, 3) |->
		o_pin_change_src_d == $past(i_portd_pin, 3)) else $error("src d");
	ch_en_a: assert property ($past(i_reset_n) |->
		o_analog_ch_en == $past(i_analog_digital_input_disable))
		else $error("analog channel flag");
	buf_off_a: assert property (
		i_analog_digital_input_disable[0] && !i_pin_change_mask_c[0] |=>
		!o_portc_input_rd[0]) else $error("disabled buffer reads");
endmodule : pcm_mux_sva

bind pcm_port_c_mux pcm_mux_sva u_pcm_mux_sva (.i_sys_clk, .i_reset_n,
	.i_reset_pin_disable_fuse, .i_two_wire_enable, .i_global_pullup_disable,
	.i_scl_out, .i_pin_change_mask_c, .i_portd_pin, .o_analog_ch_en,
	.i_analog_digital_input_disable, .o_portc_pin_out, .o_portc_pin_oe,
	.o_portc_pullup, .o_portc_output_rd, .o_portc_input_rd,
	.o_portc_direction_rd, .o_pin_change_src_d);

// ---- tb/pcm_pin_model.sv ----
// far-side pin model: pull-ups and open-drain pull-low from outside
`timescale 1ns/1ps
module pcm_pin_model (
	input wire logic [7:0] i_oe, i_out, i_pull, i_low,
	output logic [7:0] o_pin
);
	// outside pull-low wins; a released line rises only on its pull-up
	assign o_pin = ~i_low & ((i_oe & i_out) | (~i_oe & i_pull));
endmodule : pcm_pin_model

// ---- tb/port_c_alt_function_mux_bench.sv ----
// self-checking bench for the port c alternate-function mux
`timescale 1ns/1ps
module port_c_alt_function_mux_bench;
	logic clk = 1'b0, rst_n = 1'b0, fuse = 1'b0, tw = 1'b0, global_pullup_disable = 1'b0;
	logic pcie = 1'b0, scl_o = 1'b0, lo, rq, x0, x1, t0, t1, cp, cn, scl_i;
	logic sda_o = 1'b0, sda_i;
	logic [7:0] mask = 8'h00, pd = 8'h00, ext = 8'h00;
	logic [7:0] dir = 8'h40, po = 8'hff, dr;
	logic [7:0] pc, oe, pout, pull, orr, ir, sc, sd;
	logic [5:0] adid = 6'h00, ach;
	int fails = 0, compares = 0;
	always #5 clk = ~clk;
	pcm_port_c_mux u_pcm_port_c_mux (.i_sys_clk(clk), .i_reset_n(rst_n),
		.i_reset_pin_disable_fuse(fuse), .i_two_wire_enable(tw),
		.i_global_pullup_disable(global_pullup_disable), .i_pin_change_group1_enable(pcie),
		.i_pin_change_mask_c(mask), .i_analog_digital_input_disable(adid),
		.i_portc_direction(dir), .i_portc_output(po), .i_scl_out(scl_o),
		.i_sda_out(sda_o), .i_portc_pin(pc), .i_portd_pin(pd),
		.o_portc_pin_out(pout), .o_portc_pin_oe(oe), .o_portc_pullup(pull),
		.o_portc_direction_rd(dr), .o_portc_output_rd(orr), .o_sda_in(sda_i),
		.o_portc_input_rd(ir), .o_ext_reset_req(rq), .o_analog_ch_en(ach),
		.o_pin_change_src_c(sc), .o_pin_change_src_d(sd), .o_scl_in(scl_i),
		.o_external_irq_input_0(x0), .o_external_irq_input_1(x1),
		.o_timer0_count_input(t0), .o_timer1_count_input(t1),
		.o_comparator_pos_sel(cp), .o_comparator_neg_sel(cn));
	pcm_pin_model u_pcm_pin_model (.i_oe(oe), .i_out(pout), .i_pull(pull),
		.i_low(ext), .o_pin(pc));
	// compare one value and count it
	task automatic chk(input logic [7:0] v, input logic [7:0] e);
		compares++;
		fails += (v !== e);
		if (v !== e)
			$display("CHECK FAILED %0t %h %h", $time, v, e);
	endtask : chk
	// let n edges pass, then sample at the falling edge
	task automatic st(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : st
	task automatic report_and_stop;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	// watchdog: the tests need about 110 cycles
	initial
	begin
		repeat (2000) @(posedge clk);
		fails++;
		report_and_stop();
	end
	// tests: reset pin, two-wire lines, port d and analog
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		ext <= 8'h40;
		st(5);
		chk({orr[6], ir[6], rq, 5'h00}, 8'h20);
		chk({dr[6], oe[6], pull[6], 5'h00}, 8'h20);
		@(posedge clk);
		ext <= 8'h00;
		st(4);
		chk({ir[6], rq, 6'h00}, 8'h00);
		@(posedge clk);
		{fuse, ext} <= {1'b1, 8'h40};
		st(5);
		chk(ir, 8'hbf);
		chk(sc, 8'hbf);
		chk({rq, orr[6], 6'h00}, 8'h40);
		chk({dr[6], oe[6], 6'h00}, 8'hc0);
		$display("reset pin test done");
		@(posedge clk);
		{tw, scl_o, sda_o, po, ext} <= {3'b111, 8'hef, 8'h00};
		st(2);
		chk({oe[5:4], pout[5:4], pull[5:4], 2'h0}, 8'hc8);
		@(posedge clk);
		{scl_o, sda_o, po} <= {2'b00, 8'hff};
		st(12);
		lo = 1'b1;
		@(posedge clk);
		ext <= 8'h30;
		repeat (4) @(posedge clk);
		ext <= 8'h00;
		repeat (12) @(negedge clk) lo &= scl_i & sda_i;
		chk({7'h0, lo}, 8'h01);
		@(posedge clk);
		ext <= 8'h30;
		st(10);
		chk({6'h0, scl_i, sda_i}, 8'h00);
		@(posedge clk);
		{global_pullup_disable, ext} <= {1'b1, 8'h00};
		st(2);
		chk(pull, 8'h00);
		$display("two-wire test done");
		@(posedge clk);
		{tw, global_pullup_disable, adid} <= {2'b00, 6'h3f};
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			pd <= 8'h01 << i;
			st(4);
			chk(sd, 8'h01 << i);
			chk({2'h0, cn, cp, t1, t0, x1, x0}, 8'h01 << i >> 2);
		end
		chk({2'h0, ach}, 8'h3f);
		chk(ir, 8'hc0);
		@(posedge clk);
		{pcie, mask} <= {1'b1, 8'h01};
		st(2);
		chk(ir, 8'hc1);
		$display("port d and analog test done");
		report_and_stop();
	end
endmodule : port_c_alt_function_mux_bench
